// ==== hw/jcsb_pkg.sv ====
// Package for the character stream bridge: register offsets, field layouts,
// reset values and carrier structs.
// Assumes a single 32-bit AHB-Lite slave port and one clock domain.
package jcsb_pkg;

	// Register byte offsets, one aligned word each.
	localparam logic [4:0] OFF_DATA = 5'h00;
	localparam logic [4:0] OFF_CTRL = 5'h04;
	localparam logic [4:0] OFF_STAT = 5'h08;
	localparam logic [4:0] OFF_CLR = 5'h0c;
	localparam logic [4:0] OFF_IEN = 5'h10;

	// Data register fields.
	localparam int DATA_CHAR_LSB = 0;
	localparam int DATA_VALID_BIT = 15;
	localparam int DATA_AVAIL_LSB = 16;

	// Control register fields.
	localparam int CTRL_SPACE_LSB = 16;

	// Event bit positions, shared by status, clear and enable registers.
	localparam int EV_TX_LOW = 0;
	localparam int EV_RX_HIGH = 1;
	localparam int EV_WIDTH = 2;

	// Reset values.
	localparam logic [1:0] IEN_RESET = 2'h0;
	localparam logic [1:0] STAT_RESET = 2'h0;

	// AHB transfer type and size used to qualify an address phase.
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	// Link-side character carrier.
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} jcsb_char_s;

	// Captured address phase.
	typedef struct packed {
		logic write;
		logic [4:0] offset;
	} jcsb_aphase_s;

endpackage : jcsb_pkg

// ==== hw/jcsb_fifo.sv ====
// Synchronous character FIFO with level count.
// Assumes one clock, synchronous active-low reset and callers that never
// push when full or pop when empty.
`timescale 1ns/1ps
module jcsb_fifo #(
	parameter int DEPTH = 64,
	parameter int WIDTH = 8,
	parameter bit USE_REGS = 1'b0
) (
	// Clock and reset.
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// Fill side.
	input wire logic push_in,
	input wire logic [WIDTH-1:0] wdata_in,
	// Drain side.
	input wire logic pop_in,
	output logic [WIDTH-1:0] rdata_out,
	// Occupancy.
	output logic [$clog2(DEPTH):0] count_out
);
	localparam int AW = $clog2(DEPTH);

	logic [AW-1:0] wptr_q;
	logic [AW-1:0] rptr_q;
	logic [AW:0] count_q;
	logic [WIDTH-1:0] mem_q [DEPTH];

	// Storage. USE_REGS also clears every word at reset; otherwise behaviour is identical.
	generate
		if (USE_REGS) begin : g_regs
			always_ff @(posedge mclk_in) begin
				if (!rst_n_in) begin
					for (int i = 0; i < DEPTH; i++) begin
						mem_q[i] <= '0;
					end
				end else if (push_in) begin
					mem_q[wptr_q] <= wdata_in;
				end
			end
		end else begin : g_ram
			always_ff @(posedge mclk_in) begin
				if (push_in) begin
					mem_q[wptr_q] <= wdata_in;
				end
			end
		end
	endgenerate

	// Pointers and count; the head word is shown without a read latency.
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			wptr_q <= '0;
			rptr_q <= '0;
			count_q <= '0;
		end else begin
			if (push_in) begin
				wptr_q <= wptr_q + 1'b1;
			end
			if (pop_in) begin
				rptr_q <= rptr_q + 1'b1;
			end
			count_q <= count_q + (AW+1)'(push_in) - (AW+1)'(pop_in);
		end
	end

	assign rdata_out = mem_q[rptr_q];
	assign count_out = count_q;

endmodule : jcsb_fifo

// ==== hw/jcsb_bridge.sv ====
// Character stream bridge between an AHB-Lite slave port and a JTAG hub node.
// Assumes the hub delivers and accepts single characters with valid/ready,
// all on mclk_in; the hub itself multiplexes this node with others.
`timescale 1ns/1ps

// Function
// - Five 32-bit software registers, data, control, status, clear and enable, on a slave port.
// - Each transfer carries one 8-bit character in the data register.
// - Active-high interrupt for pending receive data or transmit space.
// - Transmit FIFO holds bus-written characters until the link drains them.
// - Receive FIFO holds link characters until the bus reads them.
// - Transmit depth is a power of two from 8 to 32768.
// - Receive depth is a power of two from 8 to 32768.
// - Interrupt when transmit fill falls to the transmit threshold.
// - Interrupt when receive free space falls to the receive threshold.
// - Per-FIFO option chooses flip-flops over memory, same behaviour.
// - Link side is one node of a shared multiplexing hub.
// - Simulation only, a string is preloaded into the receive FIFO at reset.
// - Simulation settings reach synthesized logic too; behaviour is unchanged only with SIM_PRELOAD clear or SIM_LEN 0.
module jcsb_bridge #(
	parameter int TX_DEPTH = 64,
	parameter int RX_DEPTH = 64,
	parameter int TX_THRESH = 8,
	parameter int RX_THRESH = 8,
	parameter bit TX_USE_REGS = 1'b0,
	parameter bit RX_USE_REGS = 1'b0,
	parameter bit SIM_PRELOAD = 1'b0,
	parameter int SIM_LEN = 0,
	parameter logic [8*16-1:0] SIM_STRING = '0
) (
	// Clock and reset.
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// AHB-Lite slave port.
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	// Hub node, host to device.
	input wire logic link_rx_valid_in,
	input wire logic [7:0] link_rx_data_in,
	output logic link_rx_ready_out,
	// Hub node, device to host.
	output logic link_tx_valid_out,
	output logic [7:0] link_tx_data_out,
	input wire logic link_tx_ready_in,
	// Interrupt.
	output logic irq_out
);
	localparam int TAW = $clog2(TX_DEPTH);
	localparam int RAW = $clog2(RX_DEPTH);

	// Depths are checked at elaboration; an illegal size fails the build.
	if (TX_DEPTH < 8 || TX_DEPTH > 32768 || (TX_DEPTH & (TX_DEPTH - 1)) != 0) begin : g_bad_tx
		$error("transmit depth must be a power of two from 8 to 32768");
	end
	if (RX_DEPTH < 8 || RX_DEPTH > 32768 || (RX_DEPTH & (RX_DEPTH - 1)) != 0) begin : g_bad_rx
		$error("receive depth must be a power of two from 8 to 32768");
	end
	// The preload string holds sixteen characters and must fit the receive FIFO.
	if (SIM_PRELOAD && (SIM_LEN > 16 || SIM_LEN > RX_DEPTH)) begin : g_bad_pre
		$error("preload string longer than its parameter or the receive fifo");
	end

	jcsb_pkg::jcsb_aphase_s ap_q;
	logic ap_valid_q;
	logic [TAW:0] tx_cnt;
	logic [RAW:0] rx_cnt;
	logic [7:0] tx_head;
	logic [7:0] rx_head;
	logic tx_push;
	logic tx_pop;
	logic rx_push;
	logic rx_pop;
	logic [7:0] rx_push_data;
	logic [jcsb_pkg::EV_WIDTH-1:0] stat_q;
	logic [jcsb_pkg::EV_WIDTH-1:0] ien_q;
	logic [jcsb_pkg::EV_WIDTH-1:0] ev_set;
	logic [jcsb_pkg::EV_WIDTH-1:0] ev_clr;
	logic [31:0] rdata_d;
	logic irq_q;
	logic tx_valid_q;
	logic [7:0] tx_data_q;
	logic rx_ready_q;
	logic [$clog2(SIM_LEN+1):0] pre_idx_q;
	logic pre_busy;
	jcsb_pkg::jcsb_char_s rx_in;

	// Address phase capture; every transfer completes with zero wait states.
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			ap_valid_q <= 1'b0;
			ap_q <= '0;
		end else if (hready_in) begin
			// Only whole words inside the 32-byte window are decoded; anything else completes
			// as an ignored access, so a stray address can never pop or push a character.
			ap_valid_q <= hsel_in && htrans_in == jcsb_pkg::HTRANS_NONSEQ &&
				hsize_in == jcsb_pkg::HSIZE_WORD && haddr_in[31:5] == 27'h0;
			ap_q.write <= hwrite_in;
			ap_q.offset <= haddr_in[4:0];
		end
	end

	// Offsets compare on the five low address bits; the window test at capture keeps
	// higher words from aliasing onto the registers.
	wire ap_data = ap_valid_q && ap_q.offset == jcsb_pkg::OFF_DATA;
	wire ap_ctrl = ap_valid_q && ap_q.offset == jcsb_pkg::OFF_CTRL;
	wire ap_stat = ap_valid_q && ap_q.offset == jcsb_pkg::OFF_STAT;
	wire ap_clr = ap_valid_q && ap_q.offset == jcsb_pkg::OFF_CLR;
	wire ap_ien = ap_valid_q && ap_q.offset == jcsb_pkg::OFF_IEN;

	// Bus data moves the FIFOs in the data phase; a full or empty FIFO ignores it.
	assign tx_push = ap_data && ap_q.write && tx_cnt != (TAW+1)'(TX_DEPTH);
	assign rx_pop = ap_data && !ap_q.write && rx_cnt != '0;

	// Link drain: one character leaves per accepted handshake.
	assign tx_pop = (!tx_valid_q || link_tx_ready_in) && tx_cnt != '0;

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			tx_valid_q <= 1'b0;
			tx_data_q <= '0;
		end else begin
			if (tx_pop) begin
				tx_valid_q <= 1'b1;
				tx_data_q <= tx_head;
			end else if (link_tx_ready_in) begin
				tx_valid_q <= 1'b0;
			end
		end
	end

	// Simulation preload: characters enter before the link is served.
	assign pre_busy = SIM_PRELOAD && 32'(pre_idx_q) < SIM_LEN;

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			pre_idx_q <= '0;
		end else if (pre_busy) begin
			pre_idx_q <= pre_idx_q + 1'b1;
		end
	end

	// Link fill; ready is registered so it is held off one entry early.
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			rx_ready_q <= 1'b0;
		end else begin
			rx_ready_q <= !pre_busy && rx_cnt < (RAW+1)'(RX_DEPTH - 1);
		end
	end

	always_comb begin
		rx_in.valid = link_rx_valid_in && rx_ready_q;
		rx_in.data = link_rx_data_in;
		if (pre_busy) begin
			rx_in.valid = 1'b1;
			rx_in.data = SIM_STRING[8*32'(pre_idx_q) +: 8];
		end
	end
	assign rx_push = rx_in.valid;
	assign rx_push_data = rx_in.data;

	jcsb_fifo #(.DEPTH(TX_DEPTH), .WIDTH(8), .USE_REGS(TX_USE_REGS)) u_tx_fifo (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.push_in(tx_push),
		.wdata_in(hwdata_in[7:0]),
		.pop_in(tx_pop),
		.rdata_out(tx_head),
		.count_out(tx_cnt)
	);

	jcsb_fifo #(.DEPTH(RX_DEPTH), .WIDTH(8), .USE_REGS(RX_USE_REGS)) u_rx_fifo (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.push_in(rx_push),
		.wdata_in(rx_push_data),
		.pop_in(rx_pop),
		.rdata_out(rx_head),
		.count_out(rx_cnt)
	);

	// Threshold events fire on the crossing edge only, so one burst gives one event.
	always_comb begin
		ev_set = '0;
		ev_set[jcsb_pkg::EV_TX_LOW] = tx_pop && !tx_push && tx_cnt == (TAW+1)'(TX_THRESH + 1);
		ev_set[jcsb_pkg::EV_RX_HIGH] = rx_push && !rx_pop &&
			(RAW+1)'(RX_DEPTH) - rx_cnt == (RAW+1)'(RX_THRESH + 1);
		ev_clr = (ap_clr && ap_q.write) ? hwdata_in[jcsb_pkg::EV_WIDTH-1:0] : '0;
	end

	// Sticky status: a set in the clearing cycle wins.
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			stat_q <= jcsb_pkg::STAT_RESET;
		end else begin
			stat_q <= (stat_q & ~ev_clr) | ev_set;
		end
	end

	// Interrupt enable register.
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			ien_q <= jcsb_pkg::IEN_RESET;
		end else if (ap_ien && ap_q.write) begin
			ien_q <= hwdata_in[jcsb_pkg::EV_WIDTH-1:0];
		end
	end

	// Level interrupt from a flip-flop, one cycle behind status.
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(stat_q & ien_q);
		end
	end

	// Read mux; data shows the popped character, its valid flag and the remaining count.
	always_comb begin
		rdata_d = '0;
		if (ap_data && !ap_q.write) begin
			rdata_d[jcsb_pkg::DATA_CHAR_LSB +: 8] = rx_cnt != '0 ? rx_head : 8'h00;
			rdata_d[jcsb_pkg::DATA_VALID_BIT] = rx_cnt != '0;
			rdata_d[jcsb_pkg::DATA_AVAIL_LSB +: 16] = 16'(rx_cnt - (RAW+1)'(rx_cnt != '0));
		end else if (ap_ctrl) begin
			rdata_d[jcsb_pkg::CTRL_SPACE_LSB +: 16] = 16'((TAW+1)'(TX_DEPTH) - tx_cnt);
			rdata_d[jcsb_pkg::EV_WIDTH-1:0] = ien_q;
		end else if (ap_stat) begin
			rdata_d[jcsb_pkg::EV_WIDTH-1:0] = stat_q;
		end else if (ap_ien) begin
			rdata_d[jcsb_pkg::EV_WIDTH-1:0] = ien_q;
		end
	end

	// Read data comes straight from the registered address phase, not from a flop of
	// its own: a registered copy would cost a wait state or return stale status after
	// a write in the preceding data phase.

	assign hrdata_out = rdata_d;
	assign hreadyout_out = 1'b1;
	assign hresp_out = 1'b0;
	assign link_tx_valid_out = tx_valid_q;
	assign link_tx_data_out = tx_data_q;
	assign link_rx_ready_out = rx_ready_q;
	assign irq_out = irq_q;

	// Buffer, event, interrupt and link hold guards.
	a_tx_no_overflow: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		tx_cnt <= (TAW+1)'(TX_DEPTH)) else $error("transmit fifo overflow");
	a_rx_no_overflow: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		rx_cnt <= (RAW+1)'(RX_DEPTH)) else $error("receive fifo overflow");
	a_tx_event_level: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		ev_set[jcsb_pkg::EV_TX_LOW] |=> tx_cnt == (TAW+1)'(TX_THRESH) && stat_q[jcsb_pkg::EV_TX_LOW])
		else $error("transmit event not at threshold");
	a_rx_event_level: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		ev_set[jcsb_pkg::EV_RX_HIGH] |=> (RAW+1)'(RX_DEPTH) - rx_cnt == (RAW+1)'(RX_THRESH))
		else $error("receive event not at threshold");
	a_irq_follows: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		|(stat_q & ien_q) |=> irq_out) else $error("interrupt missing");
	a_irq_cause: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		irq_out |-> $past(|(stat_q & ien_q))) else $error("interrupt without cause");
	a_write_pushes: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		ap_data && ap_q.write && tx_cnt == '0 |=> tx_cnt == 1 || tx_valid_q)
		else $error("data write lost");
	a_read_pops: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		rx_pop && !rx_push |=> rx_cnt == $past(rx_cnt) - 1'b1) else $error("data read did not pop");
	a_set_wins: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		ev_set[0] && ev_clr[0] |=> stat_q[0]) else $error("clear beat a new event");
	a_tx_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		link_tx_valid_out && !link_tx_ready_in |=> link_tx_valid_out && $stable(link_tx_data_out))
		else $error("link character dropped");

	// Link handshake, preload, register and interrupt guards.
	a_rx_slack: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		rx_cnt >= (RAW+1)'(RX_DEPTH - 1) |=> !link_rx_ready_out) else $error("ready kept near full");
	a_preload_gate: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		pre_busy |=> !link_rx_ready_out) else $error("link served during preload");
	a_clear_works: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		ev_clr[jcsb_pkg::EV_RX_HIGH] && !ev_set[jcsb_pkg::EV_RX_HIGH] |=> !stat_q[jcsb_pkg::EV_RX_HIGH])
		else $error("status bit not cleared");
	a_read_zero: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		!ap_valid_q |-> hrdata_out == 32'h0) else $error("read data outside a transfer");
	a_irq_idle: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		!(|(stat_q & ien_q)) |=> !irq_out) else $error("interrupt held without cause");
	a_tx_drain: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		link_tx_valid_out && link_tx_ready_in && tx_cnt == '0 |=> !link_tx_valid_out) else $error("stale link char");
	a_rx_take: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		rx_push && !rx_pop |=> rx_cnt == $past(rx_cnt) + 1'b1) else $error("link char not stored");
	a_ien_write: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		ap_ien && ap_q.write |=> ien_q == $past(hwdata_in[jcsb_pkg::EV_WIDTH-1:0]))
		else $error("enable write lost");
	a_tx_load: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		tx_pop |=> link_tx_valid_out && link_tx_data_out == $past(tx_head))
		else $error("link char not offered");

endmodule : jcsb_bridge

// ==== tb/jcsb_hub_model.sv ====
// Behavioural model of the hub node that faces the bridge's link side.
// Assumes valid/ready transfers on mclk_in; the bench fills send_q and reads got_q.
`timescale 1ns/1ps
module jcsb_hub_model (
	// Clock, reset and stall control.
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic stall_in,
	// Host to device.
	output logic rx_valid_out,
	output logic [7:0] rx_data_out,
	input wire logic rx_ready_in,
	// Device to host.
	input wire logic tx_valid_in,
	input wire logic [7:0] tx_data_in,
	output logic tx_ready_out
);
	logic [7:0] send_q[$];
	logic [7:0] got_q[$];

	// Offers queued characters and collects drained ones; an idle data line shows the
	// inverse of its last value so a stale character can never be mistaken for a new one.
	always @(posedge mclk_in) begin
		if (!rst_n_in) begin
			rx_valid_out <= 1'b0;
			rx_data_out <= 8'h00;
			tx_ready_out <= 1'b0;
		end else begin
			tx_ready_out <= !stall_in;
			if (tx_valid_in && tx_ready_out) begin
				got_q.push_back(tx_data_in);
			end
			if (!rx_valid_out || rx_ready_in) begin
				if (send_q.size() != 0) begin
					rx_valid_out <= 1'b1;
					rx_data_out <= send_q.pop_front();
				end else begin
					rx_valid_out <= 1'b0;
					rx_data_out <= ~rx_data_out;
				end
			end
		end
	end
endmodule : jcsb_hub_model

// ==== tb/jcsb_bridge_bench.sv ====
// Self-checking bench for the bridge: one bus master, one hub model.
// Assumes the zero-wait AHB-Lite slave and the register layout of the package.
`timescale 1ns/1ps
module jcsb_bridge_bench;
	localparam int DEPTH = 8;
	localparam int THRESH = 2;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic hsel = 1'b0, hwrite = 1'b0, stall = 1'b1;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic hreadyout, hresp, rx_valid, rx_ready, tx_valid, tx_ready, irq;
	logic [7:0] rx_data, tx_data;
	logic pick_pre = 1'b0;
	logic [31:0] hrdata_pre;
	int failures = 0;
	int checks_done = 0;

	// Smallest legal depths keep every fill and drain short.
	jcsb_bridge #(.TX_DEPTH(DEPTH), .RX_DEPTH(DEPTH), .TX_THRESH(THRESH), .RX_THRESH(THRESH)) i_dut (
		.mclk_in(mclk_in), .rst_n_in(rst_n_in), .hsel_in(hsel && !pick_pre), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hreadyout), .hrdata_out(hrdata),
		.hreadyout_out(hreadyout), .hresp_out(hresp), .link_rx_valid_in(rx_valid), .link_rx_data_in(rx_data),
		.link_rx_ready_out(rx_ready), .link_tx_valid_out(tx_valid), .link_tx_data_out(tx_data),
		.link_tx_ready_in(tx_ready), .irq_out(irq));
	jcsb_hub_model i_hub (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .stall_in(stall), .rx_valid_out(rx_valid),
		.rx_data_out(rx_data), .rx_ready_in(rx_ready), .tx_valid_in(tx_valid), .tx_data_in(tx_data),
		.tx_ready_out(tx_ready));
	// A second bridge with default sizes and a preloaded string; its link side stays idle.
	jcsb_bridge #(.SIM_PRELOAD(1'b1), .SIM_LEN(3), .SIM_STRING(128'h636261)) i_dut_pre (
		.mclk_in(mclk_in), .rst_n_in(rst_n_in), .hsel_in(hsel && pick_pre), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hreadyout), .hrdata_out(hrdata_pre),
		.hreadyout_out(), .hresp_out(), .link_rx_valid_in(1'b0), .link_rx_data_in(8'h00),
		.link_rx_ready_out(), .link_tx_valid_out(), .link_tx_data_out(), .link_tx_ready_in(1'b0), .irq_out());

	// Free-running 50 MHz clock.
	initial begin
		forever #10 mclk_in = ~mclk_in;
	end

	task conclude;
		$display("checks %0d, mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : conclude

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", name, exp, got);
			failures++;
		end
	endtask : chk

	// Waits for hready at a rising edge; a stuck bus ends the run.
	task wait_ready;
		int n;
		@(posedge mclk_in);
		for (n = 0; hreadyout !== 1'b1 && n < 50; n++) @(posedge mclk_in);
		if (n == 50) begin
			$display("bus wait ran out");
			failures++;
			conclude;
		end
	endtask : wait_ready

	// One single word transfer, address phase then data phase.
	task ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
		hsel <= 1'b1;
		haddr <= addr;
		htrans <= jcsb_pkg::HTRANS_NONSEQ;
		hwrite <= wr;
		wait_ready;
		htrans <= 2'h0;
		hwdata <= wdata;
		wait_ready;
		rdata = pick_pre ? hrdata_pre : hrdata;
	endtask : ahb

	task wr(input logic [31:0] addr, input logic [31:0] data);
		logic [31:0] x;
		ahb(1'b1, addr, data, x);
	endtask : wr

	task rd_chk(input string name, input logic [31:0] addr, input logic [31:0] mask, input logic [31:0] exp);
		logic [31:0] x;
		ahb(1'b0, addr, 32'h0, x);
		chk(name, exp, x & mask);
	endtask : rd_chk

	// Waits until the hub has nothing left to send and has collected the given count.
	task hub_idle(input int got);
		int n;
		for (n = 0; n < 200; n++) begin
			@(posedge mclk_in);
			if (i_hub.send_q.size() == 0 && rx_valid === 1'b0 && tx_valid === 1'b0 && i_hub.got_q.size() == got) break;
		end
		if (n == 200) begin
			$display("link wait ran out");
			failures++;
			conclude;
		end
	endtask : hub_idle

	task test_reset;
		chk("hreadyout", 32'h1, {31'h0, hreadyout});
		chk("hresp", 32'h0, {31'h0, hresp});
		chk("irq", 32'h0, {31'h0, irq});
		rd_chk("status", 32'(jcsb_pkg::OFF_STAT), 32'h3, 32'(jcsb_pkg::STAT_RESET));
		rd_chk("enable", 32'(jcsb_pkg::OFF_IEN), 32'h3, 32'(jcsb_pkg::IEN_RESET));
		rd_chk("control", 32'(jcsb_pkg::OFF_CTRL), 32'hffff0003, {16'(DEPTH), 16'h0});
		$display("test reset done");
	endtask : test_reset

	// Characters queue while the hub stalls, then drain in order and raise the event.
	// The first character already waits in the link stage, so it no longer takes FIFO space.
	task test_tx;
		wr(32'(jcsb_pkg::OFF_IEN), 32'h1);
		for (int i = 0; i < 4; i++) wr(32'(jcsb_pkg::OFF_DATA), 32'h41 + i);
		rd_chk("tx space", 32'(jcsb_pkg::OFF_CTRL), 32'hffff0003, {16'(DEPTH - 3), 16'h1});
		rd_chk("status filling", 32'(jcsb_pkg::OFF_STAT), 32'h3, 32'h0);
		stall <= 1'b0;
		hub_idle(4);
		for (int i = 0; i < 4; i++) chk("tx char", 32'h41 + i, {24'h0, i_hub.got_q[i]});
		rd_chk("status drained", 32'(jcsb_pkg::OFF_STAT), 32'h3, 32'h1);
		chk("irq tx", 32'h1, {31'h0, irq});
		wr(32'(jcsb_pkg::OFF_DATA), 32'h45);
		hub_idle(5);
		chk("tx refill", 32'h45, {24'h0, i_hub.got_q[4]});
		wr(32'(jcsb_pkg::OFF_CLR), 32'h1);
		rd_chk("status cleared", 32'(jcsb_pkg::OFF_STAT), 32'h3, 32'h0);
		chk("irq cleared", 32'h0, {31'h0, irq});
		$display("test tx done");
	endtask : test_tx

	// Six characters leave two free slots; masked first, then enabled, then read out.
	task test_rx;
		wr(32'(jcsb_pkg::OFF_IEN), 32'h0);
		for (int i = 0; i < 6; i++) i_hub.send_q.push_back(8'h61 + i);
		hub_idle(5);
		rd_chk("status full", 32'(jcsb_pkg::OFF_STAT), 32'h3, 32'h2);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(32'(jcsb_pkg::OFF_IEN), 32'h2);
		rd_chk("status again", 32'(jcsb_pkg::OFF_STAT), 32'h3, 32'h2);
		chk("irq rx", 32'h1, {31'h0, irq});
		for (int i = 0; i < 6; i++) rd_chk("rx char", 32'(jcsb_pkg::OFF_DATA), 32'h80ff, 32'h8061 + i);
		rd_chk("rx empty", 32'(jcsb_pkg::OFF_DATA), 32'h8000, 32'h0);
		wr(32'(jcsb_pkg::OFF_CLR), 32'h2);
		rd_chk("status rx cleared", 32'(jcsb_pkg::OFF_STAT), 32'h3, 32'h0);
		$display("test rx done");
	endtask : test_rx

	// An unmapped word reads zero and a write there disturbs nothing.
	task test_unmapped;
		wr(32'h20, 32'hffffffff);
		rd_chk("unmapped", 32'h20, 32'hffffffff, 32'h0);
		rd_chk("enable kept", 32'(jcsb_pkg::OFF_IEN), 32'h3, 32'h2);
		$display("test unmapped done");
	endtask : test_unmapped

	// A reset in mid-run returns the registers to their reset values.
	task test_again;
		rst_n_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		@(posedge mclk_in);
		chk("irq after reset", 32'h0, {31'h0, irq});
		rd_chk("enable reset", 32'(jcsb_pkg::OFF_IEN), 32'h3, 32'(jcsb_pkg::IEN_RESET));
		rd_chk("control reset", 32'(jcsb_pkg::OFF_CTRL), 32'hffff0003, {16'(DEPTH), 16'h0});
		$display("test again done");
	endtask : test_again

	// The preloaded string waits in the second bridge's receive FIFO after each reset.
	task test_preload;
		pick_pre <= 1'b1;
		for (int i = 0; i < 3; i++) rd_chk("preload char", 32'(jcsb_pkg::OFF_DATA), 32'hffff80ff,
			{16'(2 - i), 16'h8061 + 16'(i)});
		rd_chk("preload done", 32'(jcsb_pkg::OFF_DATA), 32'h8000, 32'h0);
		pick_pre <= 1'b0;
		$display("test preload done");
	endtask : test_preload

	// Only this one master ever touches the bridge.
	initial begin
		repeat (8) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		@(posedge mclk_in);
		test_reset;
		test_tx;
		test_rx;
		test_unmapped;
		test_again;
		test_preload;
		conclude;
	end
endmodule : jcsb_bridge_bench
